//--- ndt_tx_dma.v
// transmitting dma channel of the no-handshake word stream: words
// leave internal x memory and are driven onto the shared data bus.
// assumes one common clock, each mclk edge being one bus phase, and a
// receiver that samples the bus on the same request with no wait.
// nothing here arbitrates the data bus: the far end must stay off it.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "ndt_defs.vh"

module ndt_tx_dma #(
	parameter XMEM_DEPTH = 16,
	parameter XMEM_AW    = 4
) (
	// clock and reset
	input  wire                     mclk_i,
	input  wire                     rst_b_i,
	// register port
	input  wire [`NDT_ADDR_W-1:0]   reg_addr_i,
	input  wire [31:0]              reg_wdata_i,
	input  wire                     reg_wr_i,
	input  wire                     reg_rd_i,
	output reg  [31:0]              reg_rdata_o,
	// strap and bus pins
	input  wire                     external_request_line_b_i,
	input  wire                     bus_grant_in_b_i,
	input  wire                     transfer_acknowledge_in_b_i,
	input  wire [31:0]              ext_data_i,
	output reg  [31:0]              ext_data_o,
	output reg                      ext_data_oe_o,
	output reg  [`NDT_ADDR_W-1:0]   ext_addr_o,
	output reg                      transfer_strobe_b_o,
	// internal buses, visible for observation
	output reg  [`NDT_ADDR_W-1:0]   internal_x_address_bus_o,
	output reg  [`NDT_ADDR_W-1:0]   internal_y_address_bus_o,
	output reg  [31:0]              dma_data_o,
	output reg                      busy_o
);

	// register file
	reg [31:0]             prio_r;
	reg [31:0]             bus_ctl_r;
	reg [31:0]             port_sel_r;
	reg [31:0]             smr_r;
	reg [31:0]             dmr_r;
	reg [`NDT_ADDR_W-1:0]  sar_r;
	reg [`NDT_ADDR_W-1:0]  dar_r;
	reg [`NDT_ADDR_W-1:0]  sor_r;
	reg [`NDT_ADDR_W-1:0]  dor_r;
	reg [31:0]             cnt_r;
	reg                    en_r;
	reg                    done_r;
	reg                    wait_err_r;
	reg                    not_master_r;
	reg [1:0]              mode_r;
	reg [31:0]             bus_sample_r;
	reg [31:0]             xmem_r [0:XMEM_DEPTH-1];

	// pipeline state
	reg [1:0]              phase_r;
	reg                    st_addr_r;
	reg                    st_read_r;
	reg                    st_pins_r;
	reg [`NDT_ADDR_W-1:0]  src_hold_r;
	reg [`NDT_ADDR_W-1:0]  dst_hold_r;
	reg [`NDT_ADDR_W-1:0]  dst_pins_r;

	wire                   recog;
	wire                   last_word;
	wire                   xmem_hit;
	wire [XMEM_AW-1:0]     xmem_idx;
	wire                   sw_done_clr;
	wire                   mode_ok;
	wire                   csr_wr;
	wire                   addr_step;

	integer i;

	// index of a word inside the internal x memory window
	function [XMEM_AW-1:0] xidx;
		input [`NDT_ADDR_W-1:0] a;
		begin
			xidx = a[XMEM_AW-1:0];
		end
	endfunction

	// word offset falls inside the internal x memory window
	function in_xmem;
		input [`NDT_ADDR_W-1:0] a;
		begin
			in_xmem = (a - `NDT_OFS_XMEM) < XMEM_DEPTH;
		end
	endfunction

	// next word offset after one linear step; wraps on the 28-bit port
	function [`NDT_ADDR_W-1:0] step_addr;
		input [`NDT_ADDR_W-1:0] a;
		input [`NDT_ADDR_W-1:0] ofs;
		begin
			step_addr = a + ofs;
		end
	endfunction

	// control status word as software reads it; upper bits read zero
	function [31:0] csr_word;
		input [1:0] mode;
		input       nm;
		input       werr;
		input       dn;
		input       en;
		begin
			csr_word = {26'h0000000, mode, nm, werr, dn, en};
		end
	endfunction

	assign xmem_hit    = in_xmem(reg_addr_i);
	assign xmem_idx    = xidx(reg_addr_i);
	assign csr_wr      = reg_wr_i && (reg_addr_i == `NDT_OFS_CSR);
	assign sw_done_clr = csr_wr && reg_wdata_i[`NDT_CSR_DONE];
	// a word leaves the address stage on its T0; addresses step there
	// so that the x bus always shows the unstepped source of that word
	assign addr_step   = st_addr_r && (phase_r == `NDT_PH_T0);
	assign mode_ok     = (mode_r == `NDT_MODE_BLK_REQ);
	// the block ends with the word whose count reaches zero
	assign last_word   = (cnt_r == 32'h00000001);

	// only as bus master
	// the request is a level sampled once per instruction cycle, so one
	// held low for a whole cycle counts once, never twice
	assign recog = en_r && mode_ok && !external_request_line_b_i &&
			!bus_grant_in_b_i && (phase_r == `NDT_PH_T1);

	// phase sequencer, free running from reset at T0
	// free running so both ends count the same phases from one reset
	// four phases per word
	always @(posedge mclk_i) begin
		if (!rst_b_i)
			phase_r <= `NDT_PH_T0;
		else
			phase_r <= phase_r + 2'h1;
	end

	// transfer pipeline: one stage per phase slot, so a request every
	// four phases moves through without two words sharing a stage
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			st_addr_r                <= 1'b0;
			st_read_r                <= 1'b0;
			st_pins_r                <= 1'b0;
			src_hold_r               <= `NDT_RST_ADDR;
			dst_hold_r               <= `NDT_RST_ADDR;
			dst_pins_r               <= `NDT_RST_ADDR;
			internal_x_address_bus_o <= `NDT_RST_ADDR;
			internal_y_address_bus_o <= `NDT_RST_ADDR;
			dma_data_o               <= `NDT_RST_WORD;
			ext_data_o               <= `NDT_RST_WORD;
			ext_data_oe_o            <= 1'b0;
			ext_addr_o               <= `NDT_RST_ADDR;
			transfer_strobe_b_o      <= 1'b1;
			busy_o                   <= 1'b0;
		end else begin
			busy_o <= st_addr_r | st_read_r | st_pins_r | recog;
			if (recog)
				st_addr_r <= 1'b1;
			if (phase_r == `NDT_PH_T0) begin
				st_addr_r <= 1'b0;
				st_read_r <= st_addr_r;
				if (st_addr_r) begin
					internal_x_address_bus_o <= sar_r;
					internal_y_address_bus_o <= dar_r;
					src_hold_r               <= sar_r;
					dst_hold_r               <= dar_r;
				end
			end
			if (phase_r == `NDT_PH_T3) begin
				st_read_r <= 1'b0;
				st_pins_r <= st_read_r;
				if (st_read_r) begin
					dma_data_o <= xmem_r[xidx(src_hold_r)];
					dst_pins_r <= dst_hold_r;
				end
			end
			if (phase_r == `NDT_PH_T2) begin
				st_pins_r           <= 1'b0;
				ext_data_oe_o       <= st_pins_r;
				transfer_strobe_b_o <= !st_pins_r;
				if (st_pins_r) begin
					ext_data_o <= dma_data_o;
					ext_addr_o <= dst_pins_r;
				end
			end else begin
				// strobe lasts one phase; data stays for the cycle
				transfer_strobe_b_o <= 1'b1;
			end
		end
	end

	// channel registers, address stepping and block end
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			prio_r       <= `NDT_RST_WORD;
			bus_ctl_r    <= `NDT_RST_WORD;
			port_sel_r   <= `NDT_RST_WORD;
			smr_r        <= `NDT_RST_WORD;
			dmr_r        <= `NDT_RST_WORD;
			sar_r        <= `NDT_RST_ADDR;
			dar_r        <= `NDT_RST_ADDR;
			sor_r        <= `NDT_RST_ADDR;
			dor_r        <= `NDT_RST_ADDR;
			cnt_r        <= `NDT_RST_WORD;
			en_r         <= 1'b0;
			done_r       <= 1'b0;
			wait_err_r   <= 1'b0;
			not_master_r <= 1'b0;
			mode_r       <= 2'h0;
			bus_sample_r <= `NDT_RST_WORD;
		end else begin
			// bus level kept for software only; the receiver owns
			// capture, so no timing is promised for this copy
			bus_sample_r <= ext_data_i;
			if (reg_wr_i) begin
				case (reg_addr_i)
				// priority level kept for the core
				`NDT_OFS_INT_PRIO: prio_r     <= reg_wdata_i;
				`NDT_OFS_BUS_CTL:  bus_ctl_r  <= reg_wdata_i;
				`NDT_OFS_PORT_SEL: port_sel_r <= reg_wdata_i;
				`NDT_OFS_SMR:  smr_r  <= reg_wdata_i;
				`NDT_OFS_DMR:  dmr_r  <= reg_wdata_i;
				`NDT_OFS_SAR:  sar_r  <= reg_wdata_i[`NDT_ADDR_W-1:0];
				`NDT_OFS_DAR:  dar_r  <= reg_wdata_i[`NDT_ADDR_W-1:0];
				`NDT_OFS_SOR:  sor_r  <= reg_wdata_i[`NDT_ADDR_W-1:0];
				`NDT_OFS_DOR:  dor_r  <= reg_wdata_i[`NDT_ADDR_W-1:0];
				`NDT_OFS_CNT:  cnt_r  <= reg_wdata_i;
				`NDT_OFS_CSR: begin
					en_r   <= reg_wdata_i[`NDT_CSR_EN];
					mode_r <= reg_wdata_i[`NDT_CSR_MODE_HI:`NDT_CSR_MODE_LO];
				end
				default: ;
				endcase
			end
			// linear stepping per word
			// stepping at recognition would send the second word
			// first; a software write in the step cycle is lost
			if (addr_step) begin
				sar_r <= step_addr(sar_r, sor_r);
				dar_r <= step_addr(dar_r, dor_r);
			end
			// count is charged at recognition, so a request that
			// follows the last word is already refused
			if (recog) begin
				cnt_r <= cnt_r - 32'h00000001;
				// single block: channel stops itself on the last word
				if (last_word)
					en_r <= 1'b0;
			end
			// sticky flags: a set in the clearing cycle wins
			if (recog && last_word)
				done_r <= 1'b1;
			else if (sw_done_clr)
				done_r <= 1'b0;
			// any wait is a setup fault
			if (st_pins_r && transfer_acknowledge_in_b_i)
				wait_err_r <= 1'b1;
			else if (csr_wr && reg_wdata_i[`NDT_CSR_WAIT_ERR])
				wait_err_r <= 1'b0;
			not_master_r <= bus_grant_in_b_i;
		end
	end

	// internal x memory, loaded by software before the block starts
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			for (i = 0; i < XMEM_DEPTH; i = i + 1)
				xmem_r[i] <= `NDT_RST_WORD;
		end else if (reg_wr_i && xmem_hit) begin
			xmem_r[xmem_idx] <= reg_wdata_i;
		end
	end

	// read port: data in the cycle after the strobe, zero elsewhere
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= `NDT_RST_WORD;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
			`NDT_OFS_INT_PRIO: reg_rdata_o <= prio_r;
			`NDT_OFS_BUS_CTL:  reg_rdata_o <= bus_ctl_r;
			`NDT_OFS_PORT_SEL: reg_rdata_o <= port_sel_r;
			`NDT_OFS_SMR:  reg_rdata_o <= smr_r;
			`NDT_OFS_DMR:  reg_rdata_o <= dmr_r;
			`NDT_OFS_SAR:  reg_rdata_o <= {4'h0, sar_r};
			`NDT_OFS_DAR:  reg_rdata_o <= {4'h0, dar_r};
			`NDT_OFS_SOR:  reg_rdata_o <= {4'h0, sor_r};
			`NDT_OFS_DOR:  reg_rdata_o <= {4'h0, dor_r};
			`NDT_OFS_CNT:  reg_rdata_o <= cnt_r;
			`NDT_OFS_CSR:  reg_rdata_o <= csr_word(mode_r,
					not_master_r, wait_err_r, done_r, en_r);
			`NDT_OFS_BUS_SAMPLE: reg_rdata_o <= bus_sample_r;
			default: begin
				if (xmem_hit)
					reg_rdata_o <= xmem_r[xmem_idx];
				else
					reg_rdata_o <= `NDT_RST_WORD;
			end
			endcase
		end else begin
			reg_rdata_o <= `NDT_RST_WORD;
		end
	end

endmodule

//--- ndt_defs.vh
// register offsets, field positions and reset values for the
// transmitting dma channel; included by the channel module and bench
`ifndef NDT_DEFS_VH
`define NDT_DEFS_VH

// register word offsets on the 28-bit register port
`define NDT_ADDR_W            28
`define NDT_OFS_INT_PRIO      28'hFFFFFFF
`define NDT_OFS_BUS_CTL       28'hFFFFFFD
`define NDT_OFS_PORT_SEL      28'hFFFFFFC
`define NDT_OFS_SMR           28'hFFFFFD7
`define NDT_OFS_SAR           28'hFFFFFD6
`define NDT_OFS_SOR           28'hFFFFFD5
`define NDT_OFS_CNT           28'hFFFFFD4
`define NDT_OFS_DMR           28'hFFFFFD3
`define NDT_OFS_DAR           28'hFFFFFD2
`define NDT_OFS_DOR           28'hFFFFFD1
`define NDT_OFS_CSR           28'hFFFFFD0
`define NDT_OFS_BUS_SAMPLE    28'hFFFFFCF
// internal x memory window starts at this word offset
`define NDT_OFS_XMEM          28'h0000000

// control status fields
`define NDT_CSR_EN            0
`define NDT_CSR_DONE          1
`define NDT_CSR_WAIT_ERR      2
`define NDT_CSR_NOT_MASTER    3
`define NDT_CSR_MODE_LO       4
`define NDT_CSR_MODE_HI       5
// single block, word transfer, request triggered
`define NDT_MODE_BLK_REQ      2'h2

// reset values
`define NDT_RST_WORD          32'h00000000
`define NDT_RST_ADDR          28'h0000000

// phase codes, one phase per clock
`define NDT_PH_T0             2'h0
`define NDT_PH_T1             2'h1
`define NDT_PH_T2             2'h2
`define NDT_PH_T3             2'h3

`endif

//--- ndt_tx_checker.sv
// pin-level checks of the transmitting dma channel
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module ndt_tx_checker (
	// clock and reset
	input wire        mclk_i,
	input wire        rst_b_i,
	// watched pins
	input wire        external_request_line_b_i,
	input wire        bus_grant_in_b_i,
	input wire [31:0] dma_data_o,
	input wire [31:0] ext_data_o,
	input wire        ext_data_oe_o,
	input wire        transfer_strobe_b_o,
	input wire        busy_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// one pin word: strobe low beside driven data
	sequence s_word;
		!transfer_strobe_b_o && ext_data_oe_o;
	endsequence
	sequence s_quiet3;
		transfer_strobe_b_o [*3];
	endsequence
	property p_start_req;
		$rose(busy_o) |-> !$past(external_request_line_b_i);
	endproperty
	property p_grant;
		$rose(busy_o) |-> !$past(bus_grant_in_b_i);
	endproperty
	property p_third_t2;
		$rose(busy_o) |-> ##9 s_word;
	endproperty
	property p_strobe_oe;
		!transfer_strobe_b_o |-> ext_data_oe_o;
	endproperty
	property p_oe_hold;
		$rose(ext_data_oe_o) |-> ext_data_oe_o [*4];
	endproperty
	property p_spacing;
		s_word |=> s_quiet3;
	endproperty
	property p_data_hold;
		ext_data_oe_o && transfer_strobe_b_o |-> $stable(ext_data_o);
	endproperty
	property p_from_dma;
		s_word |-> ext_data_o == $past(dma_data_o, 3);
	endproperty
	a_start_req: assert property (p_start_req) else $error("no request");
	a_grant: assert property (p_grant) else $error("started unmastered");
	a_third_t2: assert property (p_third_t2) else $error("word late");
	a_strobe_oe: assert property (p_strobe_oe) else $error("strobe undriven");
	a_oe_hold: assert property (p_oe_hold) else $error("short drive");
	a_spacing: assert property (p_spacing) else $error("words too close");
	a_data_hold: assert property (p_data_hold) else $error("data moved");
	a_from_dma: assert property (p_from_dma) else $error("wrong pin word");
endmodule

bind ndt_tx_dma ndt_tx_checker u_chk (.mclk_i, .rst_b_i,
	.external_request_line_b_i, .bus_grant_in_b_i, .dma_data_o,
	.ext_data_o, .ext_data_oe_o, .transfer_strobe_b_o, .busy_o);

//--- ndt_rx_model.sv
// receiving dma channel on the shared data bus
// assumes the transmitter's clock and request line
`timescale 1ns/1ps
module ndt_rx_model (
	// clock and reset
	input  wire        mclk_i,
	input  wire        rst_b_i,
	// shared request and bus
	input  wire        external_request_line_b_i,
	input  wire [31:0] tx_data_i,
	input  wire        tx_oe_i,
	output wire [31:0] bus_o,
	// words taken
	output reg  [3:0]  cap_n_o
);
	reg [1:0]  ph_r;
	reg [9:0]  rec_r;
	reg [31:0] last_r;
	reg [31:0] cap_r [0:7];
	// never drives; a released bus shows no stale word
	assign bus_o = tx_oe_i ? tx_data_i : ~last_r;
	// recognise on T1, sample at the third T3
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			ph_r <= 2'h0;
			rec_r <= 10'h000;
			cap_n_o <= 4'h0;
		end else begin
			ph_r <= ph_r + 2'h1;
			rec_r <= {rec_r[8:0], ph_r == 2'h1 && !external_request_line_b_i};
			if (rec_r[9]) begin
				cap_r[cap_n_o[2:0]] <= bus_o;
				cap_n_o <= cap_n_o + 4'h1;
			end
		end
		if (tx_oe_i)
			last_r <= tx_data_i;
	end
endmodule

//--- testbench.sv
// bench for the transmitting dma channel with a receiver model
// assumes the register offsets of the shared defines header
`timescale 1ns/1ps
`include "ndt_defs.vh"
module testbench;
	reg         mclk_i, rst_b_i, wr_i, rd_i, req_b, grant_b, ack_b;
	reg  [27:0] addr;
	reg  [31:0] wdata, d;
	reg  [1:0]  ph;
	wire [31:0] rdata, bus, dout, dma;
	wire [27:0] eaddr, x_bus, y_bus;
	wire        oe, stb_b, busy;
	int         error_cnt, total_checks, cyc, i;
	ndt_tx_dma DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_i),
		.reg_rd_i(rd_i), .reg_rdata_o(rdata),
		.external_request_line_b_i(req_b), .bus_grant_in_b_i(grant_b),
		.transfer_acknowledge_in_b_i(ack_b), .ext_data_i(bus),
		.ext_data_o(dout), .ext_data_oe_o(oe), .ext_addr_o(eaddr),
		.transfer_strobe_b_o(stb_b), .internal_x_address_bus_o(x_bus),
		.internal_y_address_bus_o(y_bus), .dma_data_o(dma),
		.busy_o(busy));
	ndt_rx_model u_rx (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.external_request_line_b_i(req_b), .tx_data_i(dout),
		.tx_oe_i(oe), .bus_o(bus), .cap_n_o());
	task automatic chk(input [31:0] got, input [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input [27:0] a, input [31:0] v);
		@(posedge mclk_i);
		addr <= a;
		wdata <= v;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input [27:0] a, output [31:0] v);
		@(posedge mclk_i);
		addr <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 v = rdata;
	endtask
	// one request per cycle
	// one low pulse per word, taken at T1; ends on the taking edge
	task automatic req(input int n);
		repeat (n) begin
			do @(posedge mclk_i); while (ph != 2'h0);
			req_b <= 1'b0;
			@(posedge mclk_i);
			req_b <= 1'b1;
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	// phase of the current edge, T0 on the release edge; hang guard
	always @(posedge mclk_i) begin
		ph <= rst_b_i ? ph + 2'h1 : 2'h0;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			$display("[ERR] %0t timeout", $time);
			close_out;
		end
	end
	initial begin
		{rst_b_i, wr_i, rd_i, req_b, grant_b, ack_b} = 6'b000100;
		{addr, wdata, ph, cyc, error_cnt, total_checks} = 0;
		repeat (5) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		rd(`NDT_OFS_SAR, d);
		chk(d, 32'h00000000);
		rd(28'h0000100, d);
		chk(d, 32'h00000000);
		for (i = 3; i < 7; i++)
			wr(`NDT_OFS_XMEM + 28'(i),
				32'hA5C30000 + 32'(i));
		wr(`NDT_OFS_SOR, 32'h00000001);
		wr(`NDT_OFS_DOR, 32'h00000000);
		wr(`NDT_OFS_SAR, 32'h00000003);
		wr(`NDT_OFS_DAR, 32'h00000040);
		wr(`NDT_OFS_CNT, 32'h00000004);
		wr(`NDT_OFS_CSR, 32'h00000021);
		req(1);
		repeat (3) @(posedge mclk_i);
		#1 chk({4'h0, x_bus}, 32'h00000003);
		chk({4'h0, y_bus}, 32'h00000040);
		repeat (3) @(posedge mclk_i);
		#1 chk(dma, 32'hA5C30003);
		repeat (3) @(posedge mclk_i);
		#1 chk({oe, stb_b, 2'h0, eaddr}, 32'h80000040);
		chk(dout, 32'hA5C30003);
		$display("test single word done");
		req(3);
		repeat (12) @(posedge mclk_i);
		for (i = 0; i < 4; i++)
			chk(u_rx.cap_r[i], 32'hA5C30003 + 32'(i));
		rd(`NDT_OFS_CSR, d);
		chk(d, 32'h00000022);
		$display("test pipelined block done");
		@(posedge mclk_i);
		grant_b <= 1'b1;
		wr(`NDT_OFS_CNT, 32'h00000001);
		wr(`NDT_OFS_CSR, 32'h00000021);
		req(1);
		repeat (10) @(posedge mclk_i);
		#1 chk({30'h0, oe, busy}, 32'h00000000);
		rd(`NDT_OFS_CSR, d);
		chk(d, 32'h0000002B);
		$display("test not master done");
		// acknowledge held high during a word must flag a wait fault
		@(posedge mclk_i);
		grant_b <= 1'b0;
		ack_b <= 1'b1;
		wr(`NDT_OFS_CSR, 32'h00000023);
		req(1);
		repeat (10) @(posedge mclk_i);
		rd(`NDT_OFS_CSR, d);
		chk(d, 32'h00000026);
		$display("test wait error done");
		close_out;
	end
endmodule
